/* verilog/pvg_pkg.sv */
// constants, field layouts and carriers for the vectored interrupt gate
package pvg_pkg;
    localparam int NSRC      = 26;
    localparam int NEXT      = 9;
    localparam int NPER      = 14;
    localparam int NSHR      = 6;
    // register word addresses
    localparam logic [7:0] A_CTL0   = 8'h00;
    localparam logic [7:0] A_BASE   = 8'h40;
    localparam logic [7:0] A_FLAG   = 8'h41;
    localparam logic [7:0] A_EDGE   = 8'h42;
    localparam logic [7:0] A_SEL    = 8'h43;
    localparam logic [7:0] A_STAT   = 8'h44;
    // source control field positions
    localparam int F_LVL_LO  = 0;
    localparam int F_PEND    = 3;
    localparam int F_POL     = 4;
    localparam int F_LVS     = 5;
    // cpu flag register field positions
    localparam int F_GIE     = 0;
    localparam int F_IPL_LO  = 1;
    // select register field positions
    localparam int F_SEL03   = 0;
    localparam int F_SEL14   = 1;
    localparam int F_TWOWIRE = 2;
    // reset values and levels
    localparam logic [2:0]  LVL_OFF    = 3'h0;
    localparam logic [2:0]  IPL_RST    = 3'h0;
    localparam logic [2:0]  IPL_SPEC   = 3'h7;
    localparam logic [31:0] BASE_RST   = 32'h0000_0000;
    localparam logic [7:0]  WAKE_LIMIT = 8'h40;
    // interrupt vector numbers of each source, used for peripheral takes
    localparam logic [7:0] VEC [NSRC] = '{
        8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h1b, 8'h1a, 8'h5f, 8'h5e, 8'h5d,
        8'h50, 8'h51, 8'h52, 8'h53, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65,
        8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h28, 8'h29, 8'h21};
    typedef enum logic [1:0] {
        PVG_K_NONE = 2'b00,
        PVG_K_PER  = 2'b01,
        PVG_K_SW   = 2'b10,
        PVG_K_SPEC = 2'b11
    } pvg_kind_e;
    typedef struct packed {
        logic       sensitivity_select_bit;
        logic       line_polarity_bit;
        logic       pend;
        logic [2:0] level;
    } pvg_ctl_s;
    typedef struct packed {
        logic        valid;
        pvg_kind_e   kind;
        logic [7:0]  num;
        logic [2:0]  level;
        logic [31:0] addr;
    } pvg_take_s;
endpackage

/* verilog/pvg_gate.sv */
// prioritized vectored interrupt gate: sources, arbitration, cpu flag state
`timescale 1ns/1ps
module pvg_gate
    import pvg_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // request sources
    input  wire logic [NEXT-1:0]   ext_line,
    input  wire logic [NPER-1:0]   periph_req,
    input  wire logic [NSHR-1:0]   shared_req,
    input  wire logic              sw_req,
    input  wire logic [7:0]        sw_num,
    input  wire logic              spec_req,
    // cpu side
    output pvg_take_s              take,
    output logic                   wake_req,
    output logic                   global_enable,
    output logic      [2:0]        cpu_priority_threshold
);
    pvg_ctl_s        ctl [NSRC];
    logic [31:0]     vector_base_register;
    logic [NEXT-1:0] edge_mode_select;
    logic            shared_vector_select_03;
    logic            shared_vector_select_14;
    logic            twowire_route_enable;
    logic [NEXT-1:0] ext_prev;
    logic [NSRC-1:0] src_evt;
    logic [NSRC-1:0] acc_clr;
    logic [4:0]      win_idx;
    logic [2:0]      win_lvl;
    logic            win_ok;
    logic            next_wake;
    logic [7:0]      last_num;
    logic            flag_wr;

    assign flag_wr = reg_wr && reg_addr == A_FLAG;

    // external line edges
    always_ff @(posedge clk)
    begin
        if (rst)
            ext_prev <= '0;
        else
            ext_prev <= ext_line;
    end

    // per source request detection and control state
    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            logic evt;
            logic wr_hit;
            if (g < NEXT)
            begin : g_ext
                logic act;
                logic rise;
                logic fall;
                logic edg;
                assign act  = ctl[g].line_polarity_bit ? ext_line[g] : ~ext_line[g];
                assign rise = ext_line[g] & ~ext_prev[g];
                assign fall = ~ext_line[g] & ext_prev[g];
                assign edg  = edge_mode_select[g] ? (rise | fall)
                            : (ctl[g].line_polarity_bit ? rise : fall);
                assign evt  = ctl[g].sensitivity_select_bit ? act : edg;
            end
            else if (g < NEXT + NPER)
            begin : g_per
                assign evt = periph_req[g - NEXT];
            end
            else if (g == NEXT + NPER)
            begin : g_s03
                assign evt = shared_vector_select_03 ? shared_req[1] : shared_req[0];
            end
            else if (g == NEXT + NPER + 1)
            begin : g_s14
                assign evt = shared_vector_select_14 ? shared_req[3] : shared_req[2];
            end
            else
            begin : g_s2
                assign evt = twowire_route_enable ? shared_req[5] : shared_req[4];
            end
            assign src_evt[g] = evt;
            assign wr_hit = reg_wr && reg_addr == A_CTL0 + 8'(g);

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    ctl[g].level <= LVL_OFF;
                    ctl[g].line_polarity_bit   <= 1'b0;
                    ctl[g].sensitivity_select_bit   <= 1'b0;
                end
                else if (wr_hit)
                begin
                    ctl[g].level <= reg_wdata[F_LVL_LO +: 3];
                    ctl[g].line_polarity_bit   <= reg_wdata[F_POL];
                    ctl[g].sensitivity_select_bit   <= reg_wdata[F_LVS];
                end
            end

            // set wins over any clear
            always_ff @(posedge clk)
            begin
                if (rst)
                    ctl[g].pend <= 1'b0;
                else if (evt)
                    ctl[g].pend <= 1'b1;
                else if (acc_clr[g])
                    ctl[g].pend <= 1'b0;
                else if (wr_hit && !reg_wdata[F_PEND])
                    ctl[g].pend <= 1'b0;
            end
        end
    endgenerate

    // arbitration over pending sources
    always_comb
    begin
        win_idx = '0;
        win_lvl = '0;
        win_ok  = 1'b0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (ctl[i].pend && ctl[i].level != LVL_OFF
                && (!win_ok || ctl[i].level > win_lvl))
            begin
                win_idx = 5'(i);
                win_lvl = ctl[i].level;
                win_ok  = 1'b1;
            end
        end
    end

    // wake request only from low vector sources
    always_comb
    begin
        next_wake = 1'b0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (ctl[i].pend && ctl[i].level != LVL_OFF && VEC[i] < WAKE_LIMIT)
                next_wake = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            wake_req <= 1'b0;
        else
            wake_req <= next_wake;
    end

    // acceptance
    logic per_go;
    assign per_go = win_ok && global_enable && win_lvl > cpu_priority_threshold
                    && !spec_req && !sw_req;

    always_comb
    begin
        acc_clr = '0;
        if (per_go)
            acc_clr[win_idx] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            take <= '0;
        else if (spec_req)
        begin
            take.valid <= 1'b1;
            take.kind  <= PVG_K_SPEC;
            take.num   <= 8'h00;
            take.level <= IPL_SPEC;
            take.addr  <= 32'h0000_0000;
        end
        else if (sw_req)
        begin
            take.valid <= 1'b1;
            take.kind  <= PVG_K_SW;
            take.num   <= sw_num;
            take.level <= cpu_priority_threshold;
            take.addr  <= vector_base_register + {22'h0, sw_num, 2'b00};
        end
        else if (per_go)
        begin
            take.valid <= 1'b1;
            take.kind  <= PVG_K_PER;
            take.num   <= VEC[win_idx];
            take.level <= win_lvl;
            take.addr  <= vector_base_register + {22'h0, VEC[win_idx], 2'b00};
        end
        else
        begin
            take.valid <= 1'b0;
            take.kind  <= PVG_K_NONE;
        end
    end

    // cpu flag state: acceptance beats a same-cycle software write
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            global_enable          <= 1'b0;
            cpu_priority_threshold <= IPL_RST;
        end
        else if (spec_req)
        begin
            global_enable          <= 1'b0;
            cpu_priority_threshold <= IPL_SPEC;
        end
        else if (sw_req)
            global_enable <= 1'b0;
        else if (per_go)
        begin
            global_enable          <= 1'b0;
            cpu_priority_threshold <= win_lvl;
        end
        else if (flag_wr)
        begin
            global_enable          <= reg_wdata[F_GIE];
            cpu_priority_threshold <= reg_wdata[F_IPL_LO +: 3];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            last_num <= 8'h00;
        else if (per_go)
            last_num <= VEC[win_idx];
        else if (sw_req && !spec_req)
            last_num <= sw_num;
    end

    // configuration registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vector_base_register    <= BASE_RST;
            edge_mode_select        <= '0;
            shared_vector_select_03 <= 1'b0;
            shared_vector_select_14 <= 1'b0;
            twowire_route_enable    <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == A_BASE)
                vector_base_register <= reg_wdata;
            if (reg_addr == A_EDGE)
                edge_mode_select <= reg_wdata[NEXT-1:0];
            if (reg_addr == A_SEL)
            begin
                shared_vector_select_03 <= reg_wdata[F_SEL03];
                shared_vector_select_14 <= reg_wdata[F_SEL14];
                twowire_route_enable    <= reg_wdata[F_TWOWIRE];
            end
        end
    end

    // read data, valid only in the cycle after the strobe
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (reg_addr < A_CTL0 + 8'(NSRC))
            next_rdata = {26'h0, ctl[reg_addr[4:0]].sensitivity_select_bit, ctl[reg_addr[4:0]].line_polarity_bit,
                          ctl[reg_addr[4:0]].pend, ctl[reg_addr[4:0]].level};
        else if (reg_addr == A_BASE)
            next_rdata = vector_base_register;
        else if (reg_addr == A_FLAG)
            next_rdata = {28'h0, cpu_priority_threshold, global_enable};
        else if (reg_addr == A_EDGE)
            next_rdata = {23'h0, edge_mode_select};
        else if (reg_addr == A_SEL)
            next_rdata = {29'h0, twowire_route_enable, shared_vector_select_14,
                          shared_vector_select_03};
        else if (reg_addr == A_STAT)
            next_rdata = {24'h0, last_num};
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h0000_0000;
    end

    // checks
    a_per_needs_enable: assert property (@(posedge clk) disable iff (rst)
        take.valid && take.kind == PVG_K_PER |-> $past(global_enable)
        && take.level > $past(cpu_priority_threshold))
        else $error("peripheral taken while masked");

    a_reset_clears_gie: assert property (@(posedge clk)
        $past(rst) && !rst |-> !global_enable)
        else $error("global enable not cleared by reset");

    a_sw_always_taken: assert property (@(posedge clk) disable iff (rst)
        sw_req && !spec_req |=> take.valid && take.kind == PVG_K_SW
        && take.num == $past(sw_num))
        else $error("software request not taken");

    a_level_loads_ipl: assert property (@(posedge clk) disable iff (rst)
        take.valid && take.kind == PVG_K_PER |-> cpu_priority_threshold == take.level)
        else $error("threshold not loaded with taken level");

    a_vector_address: assert property (@(posedge clk) disable iff (rst)
        take.valid && take.kind != PVG_K_SPEC
        |-> take.addr == $past(vector_base_register) + {22'h0, take.num, 2'b00})
        else $error("vector address mismatch");

    a_pend_holds: assert property (@(posedge clk) disable iff (rst)
        ctl[0].pend && !global_enable && !(reg_wr && reg_addr == A_CTL0)
        |=> ctl[0].pend)
        else $error("pending flag lost while masked");

    a_taken_clears_pend: assert property (@(posedge clk) disable iff (rst)
        per_go && win_idx == 5'd9 && !src_evt[9] |=> !ctl[9].pend)
        else $error("pending flag not cleared on take");

    a_level_off_idle: assert property (@(posedge clk) disable iff (rst)
        per_go |-> win_lvl != LVL_OFF)
        else $error("disabled source taken");

    a_no_double_take: assert property (@(posedge clk) disable iff (rst)
        take.valid && take.kind == PVG_K_PER |-> !per_go)
        else $error("two peripheral takes back to back");

    a_rdata_one_cycle: assert property (@(posedge clk) disable iff (rst)
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

endmodule // pvg_gate

/* verif/pvg_src_model.sv */
// request source model facing the interrupt gate
`timescale 1ns/1ps
module pvg_src_model
    import pvg_pkg::*;
(
    // clock
    input  wire logic       clk,
    // request lines
    output logic [NEXT-1:0] ext_line,
    output logic [NPER-1:0] periph_req,
    output logic [NSHR-1:0] shared_req,
    output logic            sw_req,
    output logic [7:0]      sw_num,
    output logic            spec_req
);
    initial
    begin
        ext_line = '0;
        periph_req = '0;
        shared_req = '0;
        sw_req = 1'b0;
        sw_num = 8'h00;
        spec_req = 1'b0;
    end
    // one-cycle peripheral event
    task automatic pulse_periph(input int k);
        @(posedge clk);
        periph_req[k] <= 1'b1;
        @(posedge clk);
        periph_req[k] <= 1'b0;
    endtask
    // shared serial events, any mix of lines
    task automatic pulse_shared(input logic [NSHR-1:0] m);
        @(posedge clk);
        shared_req <= m;
        @(posedge clk);
        shared_req <= '0;
    endtask
    // external line moves and holds
    task automatic set_line(input int i, input logic v);
        @(posedge clk);
        ext_line[i] <= v;
        @(posedge clk);
    endtask
    // software interrupt instruction
    task automatic sw(input logic [7:0] n);
        @(posedge clk);
        sw_req <= 1'b1;
        sw_num <= n;
        @(posedge clk);
        sw_req <= 1'b0;
        sw_num <= ~n;
    endtask
    // special interrupt event
    task automatic spec;
        @(posedge clk);
        spec_req <= 1'b1;
        @(posedge clk);
        spec_req <= 1'b0;
    endtask
endmodule // pvg_src_model

/* verif/test_pvg_gate.sv */
// self-checking bench for the interrupt gate
`timescale 1ns/1ps
module test_pvg_gate;
    import pvg_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        reg_addr = 8'h00;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [31:0]       reg_rdata;
    logic [NEXT-1:0]   ext_line;
    logic [NPER-1:0]   periph_req;
    logic [NSHR-1:0]   shared_req;
    logic              sw_req;
    logic [7:0]        sw_num;
    logic              spec_req;
    pvg_take_s         take;
    logic              wake_req;
    logic              global_enable;
    logic [2:0]        cpu_priority_threshold;
    int                mismatches = 0;
    int                check_count = 0;
    localparam logic [31:0] BASE = 32'h0001_0000;

    always #12.5 clk = ~clk;

    pvg_gate pvg_gate_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_line(ext_line), .periph_req(periph_req), .shared_req(shared_req),
        .sw_req(sw_req), .sw_num(sw_num), .spec_req(spec_req), .take(take),
        .wake_req(wake_req), .global_enable(global_enable),
        .cpu_priority_threshold(cpu_priority_threshold));

    pvg_src_model pvg_src_model_inst (.clk(clk), .ext_line(ext_line),
        .periph_req(periph_req), .shared_req(shared_req), .sw_req(sw_req),
        .sw_num(sw_num), .spec_req(spec_req));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic wait_take(input pvg_kind_e k, input logic [7:0] n, input logic [31:0] a);
        #1;
        for (int i = 0; i < 6 && take.valid !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk(32'(take.valid), 32'h1);
        chk(32'(take.kind), 32'(k));
        chk(32'(take.num), 32'(n));
        chk(take.addr, a);
    endtask
    task automatic no_take;
        repeat (5)
        begin
            @(posedge clk);
            #1;
            chk(32'(take.valid), 32'h0);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_reset;
        chk(32'(global_enable), 32'h0);
        chk(32'(cpu_priority_threshold), 32'h0);
        rd(A_FLAG, 32'h0);
        rd(8'h80, 32'h0);
        wr(A_CTL0 + 8'h04, 32'h0);
        rd(A_CTL0 + 8'h04, 32'h0);
    endtask
    task automatic t_level_off;
        wr(A_CTL0 + 8'h0c, 32'h0);
        wr(A_FLAG, 32'h1);
        pvg_src_model_inst.pulse_periph(3);
        no_take();
        wr(A_FLAG, 32'h0);
    endtask
    task automatic t_masked;
        wr(A_BASE, BASE);
        wr(A_CTL0 + 8'h09, 32'h5);
        pvg_src_model_inst.pulse_periph(0);
        repeat (3) @(posedge clk);
        rd(A_CTL0 + 8'h09, 32'h0d);
        chk(32'(wake_req), 32'h0);
        wr(A_FLAG, 32'h1);
        wait_take(PVG_K_PER, 8'h50, BASE + 32'h140);
        chk(32'(cpu_priority_threshold), 32'h5);
        chk(32'(global_enable), 32'h0);
        rd(A_CTL0 + 8'h09, 32'h5);
    endtask
    task automatic t_prio;
        wr(A_CTL0 + 8'h09, 32'h3);
        wr(A_CTL0 + 8'h0a, 32'h6);
        wr(A_CTL0 + 8'h0b, 32'h6);
        pvg_src_model_inst.pulse_periph(0);
        pvg_src_model_inst.pulse_periph(1);
        pvg_src_model_inst.pulse_periph(2);
        wr(A_FLAG, 32'h0d);
        no_take();
        wr(A_FLAG, 32'h1);
        wait_take(PVG_K_PER, 8'h51, BASE + 32'h144);
        wr(A_FLAG, 32'h1);
        wait_take(PVG_K_PER, 8'h52, BASE + 32'h148);
        wr(A_FLAG, 32'h1);
        wait_take(PVG_K_PER, 8'h50, BASE + 32'h140);
        chk(32'(cpu_priority_threshold), 32'h3);
    endtask
    task automatic t_soft;
        pvg_src_model_inst.sw(8'hff);
        wait_take(PVG_K_SW, 8'hff, BASE + 32'h3fc);
        chk(32'(cpu_priority_threshold), 32'h3);
        pvg_src_model_inst.spec();
        wait_take(PVG_K_SPEC, 8'h00, 32'h0);
        chk(32'(cpu_priority_threshold), 32'h7);
        rd(A_STAT, 32'hff);
    endtask
    task automatic t_shared;
        for (int i = 23; i < 26; i++)
            wr(A_CTL0 + 8'(i), 32'h1);
        pvg_src_model_inst.pulse_shared(6'h2a);
        for (int i = 23; i < 26; i++)
            rd(A_CTL0 + 8'(i), 32'h01);
        pvg_src_model_inst.pulse_shared(6'h15);
        for (int i = 23; i < 26; i++)
            rd(A_CTL0 + 8'(i), 32'h09);
        chk(32'(wake_req), 32'h1);
        wr(A_SEL, 32'h7);
        rd(A_SEL, 32'h7);
        for (int i = 23; i < 26; i++)
            wr(A_CTL0 + 8'(i), 32'h1);
        pvg_src_model_inst.pulse_shared(6'h15);
        for (int i = 23; i < 26; i++)
            rd(A_CTL0 + 8'(i), 32'h01);
        pvg_src_model_inst.pulse_shared(6'h2a);
        for (int i = 23; i < 26; i++)
            rd(A_CTL0 + 8'(i), 32'h09);
        for (int i = 23; i < 26; i++)
            wr(A_CTL0 + 8'(i), 32'h0);
    endtask
    task automatic t_can;
        wr(A_CTL0 + 8'h16, 32'h7);
        pvg_src_model_inst.pulse_periph(13);
        wr(A_FLAG, 32'h1);
        wait_take(PVG_K_PER, 8'h7f, BASE + 32'h1fc);
        chk(32'(cpu_priority_threshold), 32'h7);
    endtask
    task automatic t_ext;
        wr(A_EDGE, 32'h0);
        wr(A_CTL0, 32'h12);
        pvg_src_model_inst.set_line(0, 1'b1);
        repeat (3) @(posedge clk);
        rd(A_CTL0, 32'h1a);
        chk(32'(wake_req), 32'h1);
        wr(A_CTL0, 32'h02);
        rd(A_CTL0, 32'h02);
        chk(32'(wake_req), 32'h0);
        pvg_src_model_inst.set_line(0, 1'b0);
        repeat (3) @(posedge clk);
        rd(A_CTL0, 32'h0a);
        wr(A_CTL0, 32'h32);
        rd(A_CTL0, 32'h32);
        pvg_src_model_inst.set_line(0, 1'b1);
        repeat (2) @(posedge clk);
        rd(A_CTL0, 32'h3a);
        pvg_src_model_inst.set_line(0, 1'b0);
        wr(A_EDGE, 32'h1);
        wr(A_CTL0, 32'h02);
        pvg_src_model_inst.set_line(0, 1'b1);
        rd(A_CTL0, 32'h0a);
        wr(A_CTL0, 32'h02);
        pvg_src_model_inst.set_line(0, 1'b0);
        rd(A_CTL0, 32'h0a);
        wr(A_CTL0, 32'h0);
        wr(A_CTL0 + 8'h01, 32'hca);
        rd(A_CTL0 + 8'h01, 32'h02);
    endtask

    initial
    begin
        #100000;
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_level_off();
        t_masked();
        t_prio();
        t_soft();
        t_ext();
        t_shared();
        t_can();
        final_report();
    end
endmodule // test_pvg_gate
